// [rtl/pmt_consts.vh]
// Purpose: Constants for the 8-bit period match timer
// Assumes: Byte-wide register port, word index addressing
// Notes: Offsets are register indices on the plain port
`ifndef PMT_CONSTS_VH
`define PMT_CONSTS_VH
`define PMT_ADDR_W 3
`define PMT_OFF_CTRL 3'h0
`define PMT_OFF_COUNT 3'h1
`define PMT_OFF_PERIOD 3'h2
`define PMT_OFF_IRQ_STAT 3'h3
`define PMT_OFF_IRQ_EN 3'h4
`define PMT_OFF_IRQ_CLR 3'h5
`define PMT_CTRL_RST 8'h00
`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hFF
`define PMT_CTRL_MASK 8'h7F
`define PMT_F_IDIV_LO 0
`define PMT_F_IDIV_HI 1
`define PMT_F_RUN 2
`define PMT_F_MDIV_LO 3
`define PMT_F_MDIV_HI 6
`define PMT_PRE_W 4
`define PMT_PRE_DIV4_LAST 4'h3
`define PMT_PRE_DIV16_LAST 4'hF
`endif

// [rtl/pmt_timer.v]
// Purpose: 8-bit period match timer with prescaler, postscaler and event flag
// Assumes: Single clock core_clk is the instruction clock; async active-low reset
// Notes: Register port with one-cycle read latency; level interrupt output
`timescale 1ns/1ps
`include "pmt_consts.vh"

module pmt_timer (
   input wire core_clk,
   input wire rstn,
   input wire sleep_req,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output wire match_pulse_serial,
   output wire match_pulse_pwm,
   output wire irq
);

////////////////////////////////////////////////////////////////////////////////
// Registers

localparam [7:0] CTRL_MASK = `PMT_CTRL_MASK;
localparam [`PMT_PRE_W-1:0] PRE_ZERO = {`PMT_PRE_W{1'b0}};

// Control and scaler state
reg [7:0] ctrl_q;
wire [7:0] ctrl_d;
reg [`PMT_PRE_W-1:0] pre_q;
reg [`PMT_PRE_W-1:0] pre_d;
reg [`PMT_PRE_W-1:0] pre_last;
reg [3:0] post_q;
reg [3:0] post_d;

// Counter and period
reg [7:0] count_q;
reg [7:0] count_d;
reg [7:0] period_q;
reg [7:0] period_d;
reg match_q;

// Event flag and its enable
reg flag_q;
reg flag_d;
reg flag_en_q;
reg flag_en_d;

// Read data and sleep synchroniser
reg [7:0] rdata_d;
reg sleep_s1_q;
reg sleep_s2_q;

// Write strobes per register index
wire wr_ctrl;
wire wr_count;
wire wr_period;
wire wr_en;
wire wr_clr;
wire clr_hit;
assign wr_ctrl = reg_wr && (reg_addr == `PMT_OFF_CTRL);
assign wr_count = reg_wr && (reg_addr == `PMT_OFF_COUNT);
assign wr_period = reg_wr && (reg_addr == `PMT_OFF_PERIOD);
assign wr_en = reg_wr && (reg_addr == `PMT_OFF_IRQ_EN);
assign wr_clr = reg_wr && (reg_addr == `PMT_OFF_IRQ_CLR);
assign clr_hit = wr_clr && reg_wdata[0];

// Read strobes per register index
wire rd_ctrl;
wire rd_count;
wire rd_period;
wire rd_stat;
wire rd_en;
assign rd_ctrl = reg_rd && (reg_addr == `PMT_OFF_CTRL);
assign rd_count = reg_rd && (reg_addr == `PMT_OFF_COUNT);
assign rd_period = reg_rd && (reg_addr == `PMT_OFF_PERIOD);
assign rd_stat = reg_rd && (reg_addr == `PMT_OFF_IRQ_STAT);
assign rd_en = reg_rd && (reg_addr == `PMT_OFF_IRQ_EN);

wire scaler_clr;
assign scaler_clr = wr_ctrl || wr_count;

// Control fields
wire [1:0] idiv_sel;
wire [3:0] mdiv_sel;
wire run_enable;
assign idiv_sel = ctrl_q[`PMT_F_IDIV_HI:`PMT_F_IDIV_LO];
assign mdiv_sel = ctrl_q[`PMT_F_MDIV_HI:`PMT_F_MDIV_LO];
assign run_enable = ctrl_q[`PMT_F_RUN];

////////////////////////////////////////////////////////////////////////////////
// Sleep input synchroniser

// Sleep comes from outside the core clock domain
always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
   end else begin
      sleep_s1_q <= sleep_req;
      sleep_s2_q <= sleep_s1_q;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Prescaler
// Holds its partial count while sleep pauses counting, so a sleep neither
// shortens nor stretches the interval in progress; any CTRL or COUNT write clears it.

always @* begin
   case (idiv_sel)
      2'b00: pre_last = PRE_ZERO;
      2'b01: pre_last = `PMT_PRE_DIV4_LAST;
      default: pre_last = `PMT_PRE_DIV16_LAST;
   endcase
end

wire active;
wire inc_tick;
assign active = run_enable && !sleep_s2_q;
assign inc_tick = active && (pre_q >= pre_last);

always @* begin
   pre_d = pre_q;
   if (scaler_clr) begin
      pre_d = PRE_ZERO;
   end else if (active) begin
      if (inc_tick) begin
         pre_d = PRE_ZERO;
      end else begin
         pre_d = pre_q + 1'b1;
      end
   end
end

always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      pre_q <= PRE_ZERO;
   end else begin
      pre_q <= pre_d;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Counter and period
// A tick lost to a register write is not made up later; the write restarts
// the prescaler from zero, a COUNT write loads the count and a CTRL write keeps it.

wire count_match;
wire match;
assign count_match = (count_q == period_q);
assign match = inc_tick && count_match && !scaler_clr;

always @* begin
   count_d = count_q;
   if (wr_count) begin
      count_d = reg_wdata;
   end else if (wr_ctrl) begin
      count_d = count_q;
   end else if (inc_tick) begin
      if (count_match) begin
         count_d = 8'h00;
      end else begin
         count_d = count_q + 8'h01;
      end
   end
end

always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      count_q <= `PMT_COUNT_RST;
   end else begin
      count_q <= count_d;
   end
end

// Period register
always @* begin
   period_d = period_q;
   if (wr_period) begin
      period_d = reg_wdata;
   end
end

always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      period_q <= `PMT_PERIOD_RST;
   end else begin
      period_q <= period_d;
   end
end

genvar gi;
generate
   for (gi = 0; gi < 8; gi = gi + 1) begin : g_ctrl_bit
      assign ctrl_d[gi] = wr_ctrl ? (reg_wdata[gi] & CTRL_MASK[gi]) : ctrl_q[gi];
   end
endgenerate

always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      ctrl_q <= `PMT_CTRL_RST;
   end else begin
      ctrl_q <= ctrl_d;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Match outputs

always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      match_q <= 1'b0;
   end else begin
      match_q <= match;
   end
end

// Both consumers see the same registered pulse
// serial shift clock source
assign match_pulse_serial = match_q;
assign match_pulse_pwm = match_q;

////////////////////////////////////////////////////////////////////////////////
// Postscaler and event flag
// A flag set and a software clear in one cycle leave the flag set.

wire post_hit;
wire post_ovf;
assign post_hit = (post_q == mdiv_sel);
assign post_ovf = match && post_hit;

always @* begin
   post_d = post_q;
   if (scaler_clr) begin
      post_d = 4'h0;
   end else if (match) begin
      if (post_ovf) begin
         post_d = 4'h0;
      end else begin
         post_d = post_q + 4'h1;
      end
   end
end

always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      post_q <= 4'h0;
   end else begin
      post_q <= post_d;
   end
end

always @* begin
   flag_d = flag_q;
   if (post_ovf) begin
      flag_d = 1'b1;
   end else if (clr_hit) begin
      flag_d = 1'b0;
   end
end

always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      flag_q <= 1'b0;
   end else begin
      flag_q <= flag_d;
   end
end

// Interrupt enable
always @* begin
   flag_en_d = flag_en_q;
   if (wr_en) begin
      flag_en_d = reg_wdata[0];
   end
end

always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      flag_en_q <= 1'b0;
   end else begin
      flag_en_q <= flag_en_d;
   end
end

// Level interrupt while flag and enable are both set
assign irq = flag_q && flag_en_q;

////////////////////////////////////////////////////////////////////////////////
// Read port

// Status and enable words
wire [7:0] stat_word;
wire [7:0] en_word;
assign stat_word = {7'h00, flag_q};
assign en_word = {7'h00, flag_en_q};

// Unmapped and write-only indices read as zero
always @* begin
   rdata_d = 8'h00;
   if (rd_ctrl) begin
      rdata_d = ctrl_q;
   end
   if (rd_count) begin
      rdata_d = count_q;
   end
   if (rd_period) begin
      rdata_d = period_q;
   end
   if (rd_stat) begin
      rdata_d = stat_word;
   end
   if (rd_en) begin
      rdata_d = en_word;
   end
end

// Read data stand for one cycle only, zero otherwise
always @(posedge core_clk or negedge rstn) begin
   if (!rstn) begin
      reg_rdata <= 8'h00;
   end else begin
      reg_rdata <= rdata_d;
   end
end

endmodule // pmt_timer

// [tb/pmt_props.sv]
// Purpose: Port checker for pmt_timer
// Assumes: One clock, rstn async low
// Notes: Bound after endmodule
`timescale 1ns/1ps
module pmt_props (
   input wire core_clk,
   input wire rstn,
   input wire sleep_req,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire match_pulse_serial,
   input wire match_pulse_pwm,
   input wire irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   a_pulse_pair: assert property (match_pulse_serial == match_pulse_pwm)
      else $error("pulses differ");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("stray read data");
   a_ctrl_top: assert property ($past(reg_rd) && $past(reg_addr) == 3'h0 |-> !reg_rdata[7])
      else $error("ctrl bit 7 set");
   a_period_back: assert property (reg_wr && reg_addr == 3'h2 ##2 reg_rd && reg_addr == 3'h2
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("period lost");
   a_irq_cause: assert property ($rose(irq) |-> match_pulse_serial || $past(reg_wr))
      else $error("irq without cause");
   a_irq_clear: assert property (reg_wr && reg_addr == 3'h5 && reg_wdata[0]
      |=> !irq || match_pulse_serial)
      else $error("irq not cleared");
   a_irq_sticky: assert property (irq && !reg_wr |=> irq)
      else $error("irq dropped");
   a_sleep_quiet: assert property (sleep_req[*4] |=> !match_pulse_serial)
      else $error("match in sleep");
   c_match: cover property (match_pulse_serial);
   c_irq: cover property ($rose(irq));
   c_sleep: cover property (sleep_req[*4]);
endmodule // pmt_props
bind pmt_timer pmt_props u_props (.core_clk, .rstn, .sleep_req, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .match_pulse_serial, .match_pulse_pwm, .irq);

// [tb/pmt_timer_tb.sv]
// Purpose: Directed bench for pmt_timer
// Assumes: 250 MHz clock
// Notes: Scenario tasks in sequence
`timescale 1ns/1ps
module pmt_timer_tb;
   logic c = 1'h0, rstn = 1'h0, slp = 1'h0, we = 1'h0, re = 1'h0;
   logic [2:0] a = 3'h0;
   logic [7:0] wd = 8'h00;
   wire [7:0] rdat;
   wire mp, irq;
   int miscompares = 0, check_count = 0, np = 0, t, n, d;
   always #2 c = ~c;
   always @(posedge c) np <= np + mp;
   pmt_timer dut (.core_clk(c), .rstn, .sleep_req(slp), .reg_addr(a), .reg_wdata(wd), .reg_wr(we),
      .reg_rd(re), .reg_rdata(rdat), .match_pulse_serial(mp), .match_pulse_pwm(), .irq);
   ////////////////////////////////////////
   task cy(int k);
      repeat (k) @(posedge c);
   endtask
   task chk(string s, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (e !== g) begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", s, e, g);
      end
   endtask
   task wr(logic [2:0] x, logic [7:0] v);
      a <= x;
      wd <= v;
      we <= 1'h1;
      cy(1);
      we <= 1'h0;
      cy(1);
   endtask
   task rd(logic [2:0] x, logic [7:0] e);
      a <= x;
      re <= 1'h1;
      cy(1);
      re <= 1'h0;
      #1 chk("rdata", e, rdat);
      cy(1);
   endtask
   ////////////////////////////////////////
   task t_reset;
      rd(3'h0, 8'h00);
      rd(3'h1, 8'h00);
      rd(3'h2, 8'hFF);
      rd(3'h7, 8'h00);
   endtask
   task t_hold;
      wr(3'h1, 8'h37);
      wr(3'h0, 8'hF8);
      cy(20);
      rd(3'h1, 8'h37);
      rd(3'h0, 8'h78);
      wr(3'h2, 8'hA5);
      rd(3'h2, 8'hA5);
   endtask
   task t_clear;
      wr(3'h2, 8'hFF);
      wr(3'h0, 8'h06);
      cy(10);
      wr(3'h1, 8'h00);
      cy(10);
      rd(3'h1, 8'h00);
      cy(4);
      rd(3'h1, 8'h01);
      wr(3'h0, 8'h00);
   endtask
   task t_pre;
      for (int i = 0; i < 4; i++) begin
         d = i == 0 ? 1 : i == 1 ? 4 : 16;
         wr(3'h2, 8'h02);
         wr(3'h0, 8'h00);
         wr(3'h1, 8'h00);
         wr(3'h0, 8'h04 | i[7:0]);
         t = np;
         cy(10 * d);
         chk("matches", 8'h03, 8'(np - t));
      end
   endtask
   task t_post(logic [3:0] ps);
      wr(3'h4, 8'h01);
      wr(3'h2, 8'h01);
      wr(3'h0, 8'h00);
      wr(3'h5, 8'h01);
      wr(3'h1, 8'h00);
      wr(3'h0, {1'h0, ps, 3'h4});
      t = np;
      n = 0;
      while (irq !== 1'h1 && n < 200) begin
         cy(1);
         n++;
      end
      cy(1);
      chk("matches", ps + 8'h01, 8'(np - t));
      wr(3'h0, 8'h00);
      rd(3'h3, 8'h01);
      wr(3'h4, 8'h00);
      chk("irq", 8'h00, irq);
      wr(3'h4, 8'h01);
      chk("irq", 8'h01, irq);
      wr(3'h5, 8'h01);
      chk("irq", 8'h00, irq);
   endtask
   task t_sleep;
      wr(3'h1, 8'h00);
      slp <= 1'h1;
      cy(3);
      wr(3'h0, 8'h04);
      cy(20);
      rd(3'h1, 8'h00);
      slp <= 1'h0;
      wr(3'h0, 8'h06);
      wr(3'h1, 8'h00);
      slp <= 1'h1;
      cy(20);
      slp <= 1'h0;
      cy(15);
      rd(3'h1, 8'h01);
   endtask
   task give_verdict;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      cy(2);
      rstn <= 1'h1;
      cy(1);
      t_reset();
      t_hold();
      t_clear();
      t_pre();
      rstn <= 1'h0;
      cy(2);
      rstn <= 1'h1;
      cy(1);
      t_reset();
      t_post(4'h0);
      t_post(4'hF);
      t_sleep();
      give_verdict();
   end
   initial begin
      #20000;
      miscompares++;
      give_verdict();
   end
endmodule // pmt_timer_tb
